// *** hdl/gpc_map.svh ***
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH

// Register indices as printed; byte address is four times the index
`define GPC_IDX_CTL_11 8'h24
`define GPC_IDX_CTL_12 8'h25
`define GPC_IDX_CTL_13 8'h26
`define GPC_IDX_CTL_14 8'h27
`define GPC_IDX_CTL_15 8'h28
`define GPC_IDX_FIRST 8'h24
`define GPC_PIN_COUNT 5
// Read-only view of synchronised pad levels, one bit per pin
`define GPC_IDX_PAD_STATE 8'h29

// Control register fields
`define GPC_BIT_DIR 0
`define GPC_BIT_POL 1
`define GPC_BIT_ALT 2
`define GPC_BIT_ODRAIN 7
`define GPC_CTL_RESET 8'h01
`define GPC_CTL_KEEP 8'h87

// AXI responses
`define GPC_RESP_OKAY 2'h0
`define GPC_RESP_SLVERR 2'h2

`endif

// *** hdl/gpc_pin.sv ***
`include "gpc_map.svh"

module gpc_pin
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Control
	input wire logic [7:0] ctl_in,
	// Pad and function side
	input wire logic pad_in,
	input wire logic gpio_out_value_in,
	input wire logic alt_drive_low_in,
	output logic pad_sync_out,
	output logic value_out,
	output logic pad_drive_out,
	output logic pad_oe_n_out
);
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic drive;
		logic oe_n;
	} pin_st_type;

	pin_st_type st_q;
	pin_st_type st_d;
	logic is_out;
	logic level;

	always_comb
	begin
		st_d = st_q;
		st_d.s1 = pad_in;
		st_d.s2 = st_q.s1;
		// Game port owns the pad: driven low to discharge, else released
		if (ctl_in[`GPC_BIT_ALT])
		begin
			is_out = alt_drive_low_in;
			level = 1'b0;
		end
		else
		begin
			is_out = ~ctl_in[`GPC_BIT_DIR];
			level = gpio_out_value_in ^ ctl_in[`GPC_BIT_POL];
		end
		st_d.drive = level;
		// Open drain only ever pulls low
		if (ctl_in[`GPC_BIT_ODRAIN])
			st_d.oe_n = ~(is_out & ~level);
		else
			st_d.oe_n = ~is_out;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			st_q <= '{s1: 1'b0, s2: 1'b0, drive: 1'b0, oe_n: 1'b1};
		else
			st_q <= st_d;
	end

	assign pad_sync_out = st_q.s2;
	assign value_out = st_q.s2 ^ ctl_in[`GPC_BIT_POL];
	assign pad_drive_out = st_q.drive;
	assign pad_oe_n_out = st_q.oe_n;

	odrain_high_a: assert property (@(posedge clk_in) disable iff (reset_in)
		$past(ctl_in[`GPC_BIT_ODRAIN]) && !$past(reset_in) && !st_q.oe_n
		|-> !st_q.drive)
		else $error("open drain drove high");
endmodule : gpc_pin

// *** hdl/gpc_pkg.sv ***
package gpc_pkg;
	typedef logic [7:0] ctl_type;
	typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_type;
	typedef enum logic [1:0] {RD_IDLE, RD_RESP} rd_state_type;
endpackage : gpc_pkg

// *** hdl/gpc_top.sv ***
`include "gpc_map.svh"

module gpc_top
(
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	// AXI4-Lite write address and data
	input wire logic [31:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	// AXI4-Lite read
	input wire logic [31:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	// Pads, index 0 is pin one of the group
	input wire logic [4:0] PAD_IN,
	output logic [4:0] PAD_OUT,
	output logic [4:0] PAD_OE_N_OUT,
	// Plain GPIO values
	input wire logic [4:0] GPIO_VALUE_IN,
	output logic [4:0] GPIO_VALUE_OUT,
	// Joystick buttons, valid only while routed
	output logic STICK1_BUTTON2_OUT,
	output logic STICK2_BUTTON1_OUT,
	output logic STICK2_BUTTON2_OUT,
	// Joystick axis timing pins
	input wire logic STICK1_XAXIS_DISCHARGE_IN,
	input wire logic STICK1_YAXIS_DISCHARGE_IN,
	output logic STICK1_XAXIS_RC_OUT,
	output logic STICK1_YAXIS_RC_OUT
);
	localparam int NPIN = `GPC_PIN_COUNT;

	typedef struct packed
	{
		gpc_pkg::ctl_type [NPIN-1:0] ctl;
		gpc_pkg::wr_state_type wst;
		gpc_pkg::rd_state_type rst;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_idx;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NPIN-1:0] val;
		logic b1;
		logic b2;
		logic b3;
		logic xrc;
		logic yrc;
	} top_st_type;

	top_st_type st_q;
	top_st_type st_d;
	logic [NPIN-1:0] pad_sync;
	logic [NPIN-1:0] pin_value;
	logic [NPIN-1:0] alt_low;
	logic [NPIN-1:0] oe_n;
	logic [NPIN-1:0] pad_drv;

	////////////////////////////////////////////////////////////////////////
	// Game-port discharge routed only to axis pins
	assign alt_low = {STICK1_YAXIS_DISCHARGE_IN, STICK1_XAXIS_DISCHARGE_IN,
		3'h0};

	for (genvar i = 0; i < NPIN; i++)
	begin : g_pin
		gpc_pin u_pin
		(
			.clk_in(REF_CLK_IN),
			.reset_in(RESET_IN),
			.ctl_in(st_q.ctl[i]),
			.pad_in(PAD_IN[i]),
			.gpio_out_value_in(GPIO_VALUE_IN[i]),
			.alt_drive_low_in(alt_low[i]),
			.pad_sync_out(pad_sync[i]),
			.value_out(pin_value[i]),
			.pad_drive_out(pad_drv[i]),
			.pad_oe_n_out(oe_n[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic idx_ok(input logic [7:0] idx);
		idx_ok = idx >= `GPC_IDX_FIRST &&
			idx < (`GPC_IDX_FIRST + 8'(NPIN));
	endfunction : idx_ok

	always_comb
	begin
		logic [7:0] ridx;
		logic [2:0] sel;
		logic [7:0] wb;
		ridx = S_AXI_ARADDR_IN[9:2];
		sel = 3'h0;
		wb = 8'h00;
		st_d = st_q;
		// Write: address and data taken independently
		if (st_q.wst == gpc_pkg::WR_IDLE)
		begin
			if (!st_q.aw_got && S_AXI_AWVALID_IN)
			begin
				st_d.aw_got = 1'b1;
				st_d.aw_idx = S_AXI_AWADDR_IN[9:2];
			end
			if (!st_q.w_got && S_AXI_WVALID_IN)
			begin
				st_d.w_got = 1'b1;
				st_d.wdata = S_AXI_WDATA_IN;
				st_d.wstrb = S_AXI_WSTRB_IN;
			end
			if (st_q.aw_got && st_q.w_got)
			begin
				st_d.aw_got = 1'b0;
				st_d.w_got = 1'b0;
				st_d.wst = gpc_pkg::WR_RESP;
				st_d.bresp = `GPC_RESP_SLVERR;
				if (idx_ok(st_q.aw_idx))
				begin
					sel = 3'(st_q.aw_idx - `GPC_IDX_FIRST);
					wb = st_q.wdata[7:0] & `GPC_CTL_KEEP;
					if (st_q.wstrb[0])
						st_d.ctl[sel] = wb;
					st_d.bresp = `GPC_RESP_OKAY;
				end
			end
		end
		else if (S_AXI_BREADY_IN)
			st_d.wst = gpc_pkg::WR_IDLE;
		// Read
		if (st_q.rst == gpc_pkg::RD_IDLE)
		begin
			if (S_AXI_ARVALID_IN)
			begin
				st_d.rst = gpc_pkg::RD_RESP;
				st_d.rdata = 32'h0;
				st_d.rresp = `GPC_RESP_OKAY;
				if (idx_ok(ridx))
				begin
					sel = 3'(ridx - `GPC_IDX_FIRST);
					st_d.rdata[7:0] = st_q.ctl[sel];
				end
				else if (ridx == `GPC_IDX_PAD_STATE)
					st_d.rdata[NPIN-1:0] = pad_sync;
				else
					st_d.rresp = `GPC_RESP_SLVERR;
			end
		end
		else if (S_AXI_RREADY_IN)
			st_d.rst = gpc_pkg::RD_IDLE;
		// Function routing: buttons inactive high, axis RC outputs low when not selected
		st_d.val = pin_value;
		for (int i = 0; i < NPIN; i++)
			if (st_q.ctl[i][`GPC_BIT_ALT])
				st_d.val[i] = 1'b0;
		st_d.b1 = st_q.ctl[0][`GPC_BIT_ALT] ? pin_value[0] : 1'b1;
		st_d.b2 = st_q.ctl[1][`GPC_BIT_ALT] ? pin_value[1] : 1'b1;
		st_d.b3 = st_q.ctl[2][`GPC_BIT_ALT] ? pin_value[2] : 1'b1;
		st_d.xrc = st_q.ctl[3][`GPC_BIT_ALT] ? pad_sync[3] : 1'b0;
		st_d.yrc = st_q.ctl[4][`GPC_BIT_ALT] ? pad_sync[4] : 1'b0;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			st_q <= '0;
			st_q.ctl <= {NPIN{`GPC_CTL_RESET}};
			st_q.b1 <= 1'b1;
			st_q.b2 <= 1'b1;
			st_q.b3 <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Ready held low while response pends so one write in flight at a time
	assign S_AXI_AWREADY_OUT = ~st_q.aw_got && st_q.wst == gpc_pkg::WR_IDLE;
	assign S_AXI_WREADY_OUT = ~st_q.w_got && st_q.wst == gpc_pkg::WR_IDLE;
	assign S_AXI_BVALID_OUT = st_q.wst == gpc_pkg::WR_RESP;
	assign S_AXI_BRESP_OUT = st_q.bresp;
	assign S_AXI_ARREADY_OUT = st_q.rst == gpc_pkg::RD_IDLE;
	assign S_AXI_RVALID_OUT = st_q.rst == gpc_pkg::RD_RESP;
	assign S_AXI_RDATA_OUT = st_q.rdata;
	assign S_AXI_RRESP_OUT = st_q.rresp;
	assign PAD_OUT = pad_drv;
	assign PAD_OE_N_OUT = oe_n;
	assign GPIO_VALUE_OUT = st_q.val;
	assign STICK1_BUTTON2_OUT = st_q.b1;
	assign STICK2_BUTTON1_OUT = st_q.b2;
	assign STICK2_BUTTON2_OUT = st_q.b3;
	assign STICK1_XAXIS_RC_OUT = st_q.xrc;
	assign STICK1_YAXIS_RC_OUT = st_q.yrc;

	////////////////////////////////////////////////////////////////////////
	reset_value_a: assert property (@(posedge REF_CLK_IN)
		$past(RESET_IN) |-> st_q.ctl[0] == `GPC_CTL_RESET)
		else $error("control not reset to one");
	reserved_zero_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) (st_q.ctl[2] & ~`GPC_CTL_KEEP) == 8'h00)
		else $error("reserved bits held");
	input_release_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[1] == 8'h01 [*2] |-> oe_n[1])
		else $error("input pin driven");
	output_drive_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[0] == 8'h00 [*2]
		|-> !oe_n[0] && pad_drv[0] == $past(GPIO_VALUE_IN[0]))
		else $error("output pin not driven");
	polarity_inv_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[0] == 8'h02 [*2]
		|-> pad_drv[0] == !$past(GPIO_VALUE_IN[0]))
		else $error("polarity not inverted");
	open_drain_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[1] == 8'h80
		##1 st_q.ctl[1] == 8'h80 && $past(GPIO_VALUE_IN[1]) |-> oe_n[1])
		else $error("open drain drove high");
	button_route_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[0] == 8'h05 [*2]
		|=> STICK1_BUTTON2_OUT == $past(pin_value[0]))
		else $error("button not routed");
	gpio_muted_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) $past(st_q.ctl[2][2]) |-> !GPIO_VALUE_OUT[2])
		else $error("gpio value during game port");
	axis_discharge_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[3] == 8'h05 ##1 st_q.ctl[3] == 8'h05
		&& $past(STICK1_XAXIS_DISCHARGE_IN) |-> !oe_n[3] && !pad_drv[3])
		else $error("axis discharge missing");
	yaxis_discharge_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[4] == 8'h05 ##1 st_q.ctl[4] == 8'h05
		&& $past(STICK1_YAXIS_DISCHARGE_IN) |-> !oe_n[4] && !pad_drv[4])
		else $error("y axis discharge missing");
	button_two_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[1] == 8'h05 [*2]
		|=> STICK2_BUTTON1_OUT == $past(pin_value[1]))
		else $error("second stick button one not routed");
	button_three_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.ctl[2] == 8'h05 [*2]
		|=> STICK2_BUTTON2_OUT == $past(pin_value[2]))
		else $error("second stick button two not routed");
	xaxis_follow_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) $past(st_q.ctl[3][`GPC_BIT_ALT])
		|-> STICK1_XAXIS_RC_OUT == $past(pad_sync[3]))
		else $error("x axis level not routed");
	yaxis_follow_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) $past(st_q.ctl[4][`GPC_BIT_ALT])
		|-> STICK1_YAXIS_RC_OUT == $past(pad_sync[4]))
		else $error("y axis level not routed");
	button_idle_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) !$past(st_q.ctl[0][`GPC_BIT_ALT])
		|-> STICK1_BUTTON2_OUT)
		else $error("button active while gpio");
	gpio_pass_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) !$past(st_q.ctl[2][`GPC_BIT_ALT])
		|-> GPIO_VALUE_OUT[2] == $past(pin_value[2]))
		else $error("gpio value not passed");
	read_answer_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
		|=> S_AXI_RVALID_OUT)
		else $error("read response late");
	write_resp_a: assert property (@(posedge REF_CLK_IN)
		disable iff (RESET_IN) st_q.aw_got && st_q.w_got |=> S_AXI_BVALID_OUT)
		else $error("write response late");
endmodule : gpc_top

// *** verif/gpc_pad_model.sv ***
module gpc_pad_model
(
	// Design side
	input wire logic [4:0] drive_in,
	input wire logic [4:0] oe_n_in,
	// Far side
	input wire logic [4:0] ext_val_in,
	input wire logic [4:0] ext_en_in,
	output logic [4:0] level_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pull-up on every pad, so a released open-drain pin reads high
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			level_out[i] = !oe_n_in[i] ? drive_in[i] :
				(ext_en_in[i] ? ext_val_in[i] : 1'b1);
	end
endmodule : gpc_pad_model

// *** verif/gpc_top_tb_top.sv ***
`include "gpc_map.svh"

module gpc_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0;
	logic ar_v = 1'b0, r_rdy = 1'b0;
	logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0;
	logic [4:0] gv = 5'h00, ext_v = 5'h00, ext_e = 5'h00;
	logic [1:0] dis = 2'h0;
	logic aw_r, w_r, b_v, ar_r, r_v;
	logic [1:0] b_resp, r_resp;
	logic [31:0] r_d;
	logic [4:0] p_out, p_oe_n, pad, gv_out;
	logic [2:0] btn;
	logic [1:0] rc;
	logic [1:0] resp;
	logic [31:0] rd;
	int err_total = 0, comparisons = 0, cyc = 0;
	//////////////////////////////////////////////////////////////////////
	initial forever #2 clk = ~clk;
	gpc_top i_gpc_top (.REF_CLK_IN(clk), .RESET_IN(rst),
		.S_AXI_AWADDR_IN(aw_a), .S_AXI_AWVALID_IN(aw_v),
		.S_AXI_AWREADY_OUT(aw_r), .S_AXI_WDATA_IN(w_d),
		.S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(w_v),
		.S_AXI_WREADY_OUT(w_r), .S_AXI_BRESP_OUT(b_resp),
		.S_AXI_BVALID_OUT(b_v), .S_AXI_BREADY_IN(b_rdy),
		.S_AXI_ARADDR_IN(ar_a), .S_AXI_ARVALID_IN(ar_v),
		.S_AXI_ARREADY_OUT(ar_r), .S_AXI_RDATA_OUT(r_d),
		.S_AXI_RRESP_OUT(r_resp), .S_AXI_RVALID_OUT(r_v),
		.S_AXI_RREADY_IN(r_rdy), .PAD_IN(pad), .PAD_OUT(p_out),
		.PAD_OE_N_OUT(p_oe_n), .GPIO_VALUE_IN(gv), .GPIO_VALUE_OUT(gv_out),
		.STICK1_BUTTON2_OUT(btn[0]), .STICK2_BUTTON1_OUT(btn[1]),
		.STICK2_BUTTON2_OUT(btn[2]), .STICK1_XAXIS_DISCHARGE_IN(dis[0]),
		.STICK1_YAXIS_DISCHARGE_IN(dis[1]), .STICK1_XAXIS_RC_OUT(rc[0]),
		.STICK1_YAXIS_RC_OUT(rc[1]));
	gpc_pad_model i_gpc_pad_model (.drive_in(p_out), .oe_n_in(p_oe_n),
		.ext_val_in(ext_v), .ext_en_in(ext_e), .level_out(pad));
	//////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Bus waits are open-ended; the cycle ceiling below catches a hang
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		logic a, d;
		a = 1'b0;
		d = 1'b0;
		aw_a <= {22'h0, idx, 2'h0};
		w_d <= {24'h0, val};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		while (!(a && d))
		begin
			@(posedge clk);
			if (!a && aw_r)
			begin
				a = 1'b1;
				aw_v <= 1'b0;
			end
			if (!d && w_r)
			begin
				d = 1'b1;
				w_v <= 1'b0;
			end
		end
		do @(posedge clk); while (!b_v);
		resp = b_resp;
		b_rdy <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rdr(input logic [7:0] idx);
		ar_a <= {22'h0, idx, 2'h0};
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		do @(posedge clk); while (!ar_r);
		ar_v <= 1'b0;
		while (!r_v) @(posedge clk);
		rd = r_d;
		resp = r_resp;
		r_rdy <= 1'b0;
		@(posedge clk);
	endtask : rdr
	// Pad path is one cycle to drive plus two edges of sync
	task automatic settle;
		repeat (6) @(posedge clk);
	endtask : settle
	//////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end
	initial
	begin
		logic [7:0] ix;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 5; i++)
		begin
			rdr(8'(`GPC_IDX_FIRST + i));
			chk(rd, 32'h01);
		end
		rdr(8'h30);
		chk(32'(resp), 32'h2);
		chk(rd, 32'h0);
		wr(`GPC_IDX_CTL_11, 8'hFF);
		rdr(`GPC_IDX_CTL_11);
		chk(rd, 32'h87);
		wr(8'h30, 8'h00);
		chk(32'(resp), 32'h2);
		$display("test registers done");
		for (int i = 0; i < 5; i++)
		begin
			ix = 8'(`GPC_IDX_FIRST + i);
			ext_e <= 5'h00;
			gv <= 5'h1F;
			wr(ix, 8'h00);
			settle();
			chk(32'(p_oe_n[i]), 32'h0);
			chk(32'(pad[i]), 32'h1);
			wr(ix, 8'h02);
			settle();
			chk(32'(pad[i]), 32'h0);
			wr(ix, 8'h80);
			settle();
			chk(32'(p_oe_n[i]), 32'h1);
			gv <= 5'h00;
			settle();
			chk(32'(p_oe_n[i]), 32'h0);
			chk(32'(p_out[i]), 32'h0);
			ext_e <= 5'h1F;
			ext_v <= 5'h00;
			wr(ix, 8'h01);
			settle();
			chk(32'(p_oe_n[i]), 32'h1);
			chk(32'(gv_out[i]), 32'h0);
			if (i < 3)
				chk(32'(btn[i]), 32'h1);
			wr(ix, 8'h03);
			settle();
			chk(32'(gv_out[i]), 32'h1);
			wr(ix, 8'h05);
			settle();
			chk(32'(p_oe_n[i]), 32'h1);
			chk(32'(gv_out[i]), 32'h0);
			if (i < 3)
				chk(32'(btn[i]), 32'h0);
			else
			begin
				chk(32'(rc[i - 3]), 32'h0);
				ext_v <= 5'h1F;
				settle();
				chk(32'(rc[i - 3]), 32'h1);
				ext_e <= 5'h00;
				dis <= 2'h3;
				settle();
				chk(32'(p_oe_n[i]), 32'h0);
				chk(32'(p_out[i]), 32'h0);
				dis <= 2'h0;
			end
			wr(ix, 8'h01);
		end
		ext_e <= 5'h1F;
		ext_v <= 5'h15;
		settle();
		rdr(`GPC_IDX_PAD_STATE);
		chk(rd, 32'h15);
		$display("test pins done");
		summarize();
	end
endmodule : gpc_top_tb_top
